// *** pkg/pcs_map.svh ***
// Constants for the configuration select and special cycle block
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
`define PCS_ADDR_POINTER 32'h0000_0000
`define PCS_ADDR_DATA 32'h0000_0004
`define PCS_ADDR_BUSNUM 32'h0000_0008
`define PCS_ADDR_STATUS 32'h0000_000C
`define PCS_ADDR_TGTCTL 32'h0000_0010
`define PCS_ADDR_CFGRAM 32'h0000_0100
`define PCS_PTR_EN_BIT 31
`define PCS_PTR_BUS_HI 23
`define PCS_PTR_BUS_LO 16
`define PCS_PTR_DEV_HI 15
`define PCS_PTR_DEV_LO 11
`define PCS_PTR_FN_HI 10
`define PCS_PTR_FN_LO 8
`define PCS_PTR_REG_HI 7
`define PCS_PTR_REG_LO 2
`define PCS_PTR_WMASK 32'h80FF_FFFC
`define PCS_CMD_SPECIAL 4'h1
`define PCS_CMD_CFG_RD 4'hA
`define PCS_CMD_CFG_WR 4'hB
`define PCS_ALL_ONES 32'hFFFF_FFFF
`define PCS_FN_MASK_RST 8'h01
`define PCS_IDSEL_BASE 16
`endif

// *** pkg/pcs_pkg.sv ***
// Types for the configuration select and special cycle block
`default_nettype none
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_IDLE = 2'h0,
    PCS_ADDR = 2'h1,
    PCS_DATA = 2'h3,
    PCS_DONE = 2'h2
  } pcs_state_type;
endpackage
`default_nettype wire

// *** logic/pcs_idsel_dec.sv ***
// Device number to select line decoder
`timescale 1ns/100ps
`default_nettype none
`include "pcs_map.svh"
module pcs_idsel_dec (
  input wire logic [4:0] dev_in,
  output logic [31:0] ad_sel_out
);
  // One line per device 0..15 on AD[31:16]; others select nothing
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_sel
      if (g >= `PCS_IDSEL_BASE) begin : g_hi
        assign ad_sel_out[g] = (dev_in == 5'(g - `PCS_IDSEL_BASE));
      end else begin : g_lo
        assign ad_sel_out[g] = 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** logic/pcs_cfg_target.sv ***
// Type 0 configuration target decode with a small config store
`timescale 1ns/100ps
`default_nettype none
`include "pcs_map.svh"
module pcs_cfg_target (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic multi_fn_in,
  input wire logic fn0_only_in,
  input wire logic [7:0] fn_mask_in,
  input wire logic addr_phase_in,
  input wire logic [3:0] cmd_in,
  input wire logic idsel_in,
  input wire logic [31:0] ad_in,
  input wire logic data_phase_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  output logic claim_out,
  output logic disc_out,
  output logic [31:0] rdata_out
);
  logic [31:0] cfg_mem [0:63];
  logic [5:0] idx_ff;
  logic active_ff;
  logic first_ff;
  logic wr_ff;
  wire is_cfg = (cmd_in == `PCS_CMD_CFG_RD) || (cmd_in == `PCS_CMD_CFG_WR);
  wire [2:0] fn = ad_in[10:8];
  // Multi-function decode ignores AD[31:11]; function 0 always present
  wire fn_ok = multi_fn_in ? (fn_mask_in[fn] | (fn == 3'h0)) : (!fn0_only_in || fn == 3'h0);
  // IDSEL looked at only in the address phase of a config command
  wire hit = addr_phase_in && is_cfg && idsel_in && (ad_in[1:0] == 2'h0) && fn_ok;
  assign claim_out = hit;
  assign disc_out = active_ff && data_phase_in && !first_ff;
  assign rdata_out = cfg_mem[idx_ff];
  // Track the DWORD index, stepping linearly in a burst
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      idx_ff <= 6'h0;
      active_ff <= 1'b0;
      first_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else if (hit) begin
      idx_ff <= ad_in[7:2];
      active_ff <= 1'b1;
      first_ff <= 1'b1;
      wr_ff <= (cmd_in == `PCS_CMD_CFG_WR);
    end else if (active_ff && data_phase_in) begin
      idx_ff <= idx_ff + 6'h1;
      first_ff <= 1'b0;
    end else if (!data_phase_in && !addr_phase_in) begin
      active_ff <= 1'b0;
    end
  end
  // Every byte enable pattern is honoured, one lane per bit
  wire [31:0] merged;
  wire store = active_ff && first_ff && wr_ff && data_phase_in;
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_lane
      assign merged[8*b +: 8] = be_in[b] ? wdata_in[8*b +: 8] : cfg_mem[idx_ff][8*b +: 8];
    end
  endgenerate
  // One writer for the store; only the first data phase lands
  always_ff @(posedge mclk_in) begin
    if (store) begin
      cfg_mem[idx_ff] <= merged;
    end
  end
endmodule
`default_nettype wire

// *** logic/pcs_top.sv ***
// Host bridge config mechanism with special cycle, plus Type 0 target
// Functional notes
// - Special cycle generation is optional; here it is present.
// - Pointer write own bus, dev/fn all ones, reg zero arms special cycle.
// - Armed data write issues special cycle command, data on AD first phase.
// - Armed data read runs Type 0 read, master-abort returns all ones.
// - Bus mismatch forwards data window write as Type 1 transaction.
// - Single function claims on config command, IDSEL and AD[1:0]=00.
// - Single function may alias all functions or claim only function 0.
// - Multi function decodes function field, claims implemented ones only.
// - Function 0 always implemented; others any of 1..7.
// - Multi function ignores AD[31:11] on register access.
// - AD[7:2] selects DWORD, byte enables select bytes.
// - Every byte enable pattern accepted.
// - Bursts may end by disconnect, never target-abort.
// - Burst data phases step one DWORD upward.
// - Target uses a real IDSEL input, not an AD line.
// - IDSEL sampled only in config address phase.
// - Pointer fields: enable 31, bus 23:16, dev 15:11, fn 10:8, reg 7:2.
// - Type 0: decode device to select, AD[1:0]=00, copy fn and reg.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_map.svh"
module pcs_top (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic frame_out,
  output logic [3:0] cmd_out,
  output logic [31:0] ad_out,
  output logic [3:0] be_out,
  output logic data_phase_out,
  input wire logic devsel_in,
  input wire logic idsel_pin_in,
  input wire logic t_addr_phase_in,
  input wire logic [3:0] t_cmd_in,
  input wire logic [31:0] t_ad_in,
  input wire logic t_data_phase_in,
  input wire logic [3:0] t_be_in,
  output logic t_claim_out,
  output logic t_disc_out,
  output logic [31:0] t_rdata_out
);
  // =====================================================================
  // Registers
  // =====================================================================
  logic [31:0] ptr_ff;
  logic [7:0] busnum_ff;
  logic armed_ff;
  logic mabort_ff;
  logic multi_fn_ff;
  logic fn0_only_ff;
  logic [7:0] fn_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  pcs_pkg::pcs_state_type st_ff;
  logic frame_ff;
  logic [3:0] cmd_ff;
  logic [31:0] ad_ff;
  logic [3:0] be_ff;
  logic dph_ff;
  logic [31:0] wd_ff;
  logic rd_ff;
  logic [1:0] ids_sync_ff;
  logic ids_q3_ff;
  logic ids_ff;
  logic claim_ff;
  logic disc_ff;
  logic [31:0] trd_ff;
  // =====================================================================
  // Bus decode
  // =====================================================================
  wire acc = psel_in && penable_in;
  wire sel_ptr = (paddr_in == `PCS_ADDR_POINTER);
  wire sel_data = (paddr_in == `PCS_ADDR_DATA);
  wire sel_bus = (paddr_in == `PCS_ADDR_BUSNUM);
  wire sel_stat = (paddr_in == `PCS_ADDR_STATUS);
  wire sel_tctl = (paddr_in == `PCS_ADDR_TGTCTL);
  wire mapped = sel_ptr || sel_data || sel_bus || sel_stat || sel_tctl;
  wire [31:0] ptr_new = pwdata_in & `PCS_PTR_WMASK;
  // Arming pattern on the incoming pointer value
  wire arm_pat = (ptr_new[`PCS_PTR_BUS_HI:`PCS_PTR_BUS_LO] == busnum_ff) &&
                 (&ptr_new[`PCS_PTR_DEV_HI:`PCS_PTR_FN_LO]) &&
                 (ptr_new[`PCS_PTR_REG_HI:`PCS_PTR_REG_LO] == 6'h0);
  wire bus_match = (ptr_ff[`PCS_PTR_BUS_HI:`PCS_PTR_BUS_LO] == busnum_ff);
  wire xlate = ptr_ff[`PCS_PTR_EN_BIT];
  wire [31:0] idsel_lines;
  // Data window accesses with the enable bit set wait for the bus transaction
  wire data_go = acc && sel_data && xlate && (st_ff == pcs_pkg::PCS_IDLE) && !pready_ff;
  wire [31:0] reg_rd = sel_ptr ? ptr_ff :
                       sel_bus ? {24'h0, busnum_ff} :
                       sel_stat ? {30'h0, armed_ff, mabort_ff} :
                       sel_tctl ? {22'h0, fn_mask_ff, fn0_only_ff, multi_fn_ff} : 32'h0;
  // Address phase word for Type 0, Type 1 or special cycle
  wire [31:0] t0_ad = idsel_lines | {21'h0, ptr_ff[`PCS_PTR_FN_HI:`PCS_PTR_REG_LO], 2'h0};
  wire [31:0] t1_ad = {8'h0, ptr_ff[23:2], 2'h1};
  wire [3:0] nxt_cmd = (armed_ff && pwrite_in) ? `PCS_CMD_SPECIAL :
                       pwrite_in ? `PCS_CMD_CFG_WR : `PCS_CMD_CFG_RD;
  wire [31:0] nxt_ad = (armed_ff && pwrite_in) ? 32'h0 : (bus_match ? t0_ad : t1_ad);
  wire data_end = (st_ff == pcs_pkg::PCS_DATA) && (devsel_in || cmd_ff == `PCS_CMD_SPECIAL);
  wire data_abort = (st_ff == pcs_pkg::PCS_DATA) && !devsel_in && cmd_ff != `PCS_CMD_SPECIAL;
  pcs_idsel_dec u_dec (
    .dev_in(ptr_ff[`PCS_PTR_DEV_HI:`PCS_PTR_DEV_LO]),
    .ad_sel_out(idsel_lines)
  );
  // =====================================================================
  // Register file and bus answer
  // =====================================================================
  // Pointer, bus number and target control writes; arming follows pointer writes
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_ff <= 32'h0;
      busnum_ff <= 8'h0;
      armed_ff <= 1'b0;
      multi_fn_ff <= 1'b0;
      fn0_only_ff <= 1'b0;
      fn_mask_ff <= `PCS_FN_MASK_RST;
    end else if (acc && pwrite_in && !pready_ff) begin
      if (sel_ptr) begin
        ptr_ff <= ptr_new;
        armed_ff <= arm_pat;
      end else if (sel_bus) begin
        busnum_ff <= pwdata_in[7:0];
      end else if (sel_tctl) begin
        multi_fn_ff <= pwdata_in[0];
        fn0_only_ff <= pwdata_in[1];
        fn_mask_ff <= pwdata_in[9:2] | `PCS_FN_MASK_RST;
      end
    end
  end
  // Master-abort flag: set wins over clear by status write
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      mabort_ff <= 1'b0;
    end else if (data_abort) begin
      mabort_ff <= 1'b1;
    end else if (acc && pwrite_in && sel_stat && pwdata_in[0] && !pready_ff) begin
      mabort_ff <= 1'b0;
    end
  end
  // Ready: registers and a data window with enable clear answer at once, an enabled data window after the bus cycle
  wire reg_ready = acc && !pready_ff && !(sel_data && xlate);
  wire win_ready = (st_ff == pcs_pkg::PCS_DONE);
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= reg_ready || win_ready;
      pslverr_ff <= reg_ready && !mapped;
      prdata_ff <= win_ready ? (rd_ff ? wd_ff : 32'h0) : (sel_data ? `PCS_ALL_ONES : reg_rd);
    end
  end
  // =====================================================================
  // Initiator sequence
  // =====================================================================
  // Idle, address phase, data phase, done
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_ff <= pcs_pkg::PCS_IDLE;
      frame_ff <= 1'b0;
      cmd_ff <= 4'h0;
      ad_ff <= 32'h0;
      be_ff <= 4'h0;
      dph_ff <= 1'b0;
      wd_ff <= 32'h0;
      rd_ff <= 1'b0;
    end else begin
      case (st_ff)
        pcs_pkg::PCS_IDLE: begin
          if (data_go) begin
            st_ff <= pcs_pkg::PCS_ADDR;
            frame_ff <= 1'b1;
            cmd_ff <= nxt_cmd;
            ad_ff <= nxt_ad;
            be_ff <= 4'hF;
            wd_ff <= pwdata_in;
            rd_ff <= !pwrite_in;
          end
        end
        pcs_pkg::PCS_ADDR: begin
          st_ff <= pcs_pkg::PCS_DATA;
          frame_ff <= 1'b0;
          dph_ff <= 1'b1;
          ad_ff <= rd_ff ? 32'h0 : wd_ff;
        end
        pcs_pkg::PCS_DATA: begin
          if (data_end || data_abort) begin
            st_ff <= pcs_pkg::PCS_DONE;
            dph_ff <= 1'b0;
            wd_ff <= data_abort ? `PCS_ALL_ONES : t_rdata_out;
          end
        end
        default: begin
          st_ff <= pcs_pkg::PCS_IDLE;
          ad_ff <= 32'h0;
          be_ff <= 4'h0;
        end
      endcase
    end
  end
  // =====================================================================
  // Target side
  // =====================================================================
  // Three-stage sync on the select pin; a change counts when stages two and three agree
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ids_sync_ff <= 2'h0;
      ids_q3_ff <= 1'b0;
      ids_ff <= 1'b0;
    end else begin
      ids_sync_ff <= {ids_sync_ff[0], idsel_pin_in};
      ids_q3_ff <= ids_sync_ff[1];
      if (ids_sync_ff[1] == ids_q3_ff) begin
        ids_ff <= ids_q3_ff;
      end
    end
  end
  wire claim_w;
  wire disc_w;
  wire [31:0] rdata_w;
  pcs_cfg_target u_tgt (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .multi_fn_in(multi_fn_ff),
    .fn0_only_in(fn0_only_ff),
    .fn_mask_in(fn_mask_ff),
    .addr_phase_in(t_addr_phase_in),
    .cmd_in(t_cmd_in),
    .idsel_in(ids_ff),
    .ad_in(t_ad_in),
    .data_phase_in(t_data_phase_in),
    .be_in(t_be_in),
    .wdata_in(t_ad_in),
    .claim_out(claim_w),
    .disc_out(disc_w),
    .rdata_out(rdata_w)
  );
  // Registered target outputs
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      claim_ff <= 1'b0;
      disc_ff <= 1'b0;
      trd_ff <= 32'h0;
    end else begin
      claim_ff <= claim_w;
      disc_ff <= disc_w;
      trd_ff <= rdata_w;
    end
  end
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign frame_out = frame_ff;
  assign cmd_out = cmd_ff;
  assign ad_out = ad_ff;
  assign be_out = be_ff;
  assign data_phase_out = dph_ff;
  assign t_claim_out = claim_ff;
  assign t_disc_out = disc_ff;
  assign t_rdata_out = trd_ff;
  // =====================================================================
  // Checks
  // =====================================================================
  sequence s_arm_write;
    acc && pwrite_in && sel_ptr && !pready_ff && arm_pat;
  endsequence
  a_arm_on_pattern: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_arm_write |=> armed_ff) else $error("pattern did not arm");
  a_disarm_other_ptr: assert property (@(posedge mclk_in) disable iff (reset_in)
    acc && pwrite_in && sel_ptr && !pready_ff && !arm_pat |=> !armed_ff) else $error("arm not cleared");
  a_special_cmd: assert property (@(posedge mclk_in) disable iff (reset_in)
    data_go && armed_ff && pwrite_in |=> cmd_out == `PCS_CMD_SPECIAL) else $error("no special cmd");
  a_special_data: assert property (@(posedge mclk_in) disable iff (reset_in)
    data_go && armed_ff && pwrite_in |=> ##1 ad_out == $past(pwdata_in, 2)) else $error("bad special data");
  a_type1_fwd: assert property (@(posedge mclk_in) disable iff (reset_in)
    data_go && !armed_ff && !bus_match |=> ad_out[1:0] == 2'h1) else $error("not type 1");
  a_type0_addr: assert property (@(posedge mclk_in) disable iff (reset_in)
    data_go && !(armed_ff && pwrite_in) && bus_match |=> ad_out[1:0] == 2'h0 && ad_out[10:2] == $past(ptr_ff[10:2]))
    else $error("bad type 0 addr");
  a_abort_ones: assert property (@(posedge mclk_in) disable iff (reset_in)
    data_abort |=> mabort_ff ##1 prdata_out == `PCS_ALL_ONES || !rd_ff) else $error("abort data");
  a_claim_needs_sel: assert property (@(posedge mclk_in) disable iff (reset_in)
    t_claim_out |-> $past(ids_ff) && $past(t_ad_in[1:0]) == 2'h0 && $past(t_addr_phase_in)) else $error("bad claim");
  a_onehot_sel: assert property (@(posedge mclk_in) disable iff (reset_in)
    $onehot0(idsel_lines) && idsel_lines[15:0] == 16'h0) else $error("select not unique");
  a_pready_pulse: assert property (@(posedge mclk_in) disable iff (reset_in)
    pready_ff |=> !pready_ff) else $error("ready stuck");
endmodule
`default_nettype wire

// *** sim/pcs_bus_tgt.sv ***
// Bus target model that claims configuration cycles on one select line
`timescale 1ns/100ps
`default_nettype none
module pcs_bus_tgt #(
  parameter int SEL_BIT = 19
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic frame_in,
  input wire logic [3:0] cmd_in,
  input wire logic [31:0] ad_in,
  input wire logic data_phase_in,
  output logic devsel_out
);
  logic hit_ff;
  logic hit;
  // ==========================================
  // Claim decode, looked at in the address phase only
  assign hit = frame_in & ad_in[SEL_BIT] & (ad_in[1:0] == 2'h0) & (cmd_in[3:1] == 3'h5);
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      hit_ff <= 1'b0;
    end else if (frame_in) begin
      hit_ff <= hit;
    end else if (!data_phase_in) begin
      hit_ff <= 1'b0;
    end
  end
  // Claim shows during data phases; a released line idles low
  assign devsel_out = hit_ff & data_phase_in;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking testbench for the configuration select and special cycle block
`timescale 1ns/100ps
`default_nettype none
`include "pcs_map.svh"
module tb_top;
  logic mclk_in, reset_in, psel_in, penable_in, pwrite_in, devsel_in, idsel_pin_in, t_addr_phase_in, t_data_phase_in;
  logic [31:0] paddr_in, pwdata_in, t_ad_in, prdata_out, ad_out, t_rdata_out, rd_v, cap_addr, cap_data, cap_trd;
  logic [3:0] t_cmd_in, t_be_in, cmd_out, be_out, cap_cmd, cap_be;
  logic pready_out, pslverr_out, frame_out, data_phase_out, t_claim_out, t_disc_out, dp_q, err_v, tdp_q, grab_q;
  int error_cnt = 0, num_checks = 0, cyc = 0, claim_cnt = 0, disc_cnt = 0;

  pcs_top pcs_top_i (.mclk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .frame_out, .cmd_out, .ad_out, .be_out, .data_phase_out,
    .devsel_in, .idsel_pin_in, .t_addr_phase_in, .t_cmd_in, .t_ad_in, .t_data_phase_in, .t_be_in,
    .t_claim_out, .t_disc_out, .t_rdata_out);
  pcs_bus_tgt #(.SEL_BIT(19)) pcs_bus_tgt_i (.mclk_in, .reset_in, .frame_in(frame_out), .cmd_in(cmd_out),
    .ad_in(ad_out), .data_phase_in(data_phase_out), .devsel_out(devsel_in));

  // ==========================================
  // Clock, bus monitor and hang guard
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    dp_q <= data_phase_out;
    // Target read data stands one cycle after the first data phase
    tdp_q <= t_data_phase_in;
    grab_q <= (t_data_phase_in === 1'b1 && tdp_q !== 1'b1);
    if (grab_q === 1'b1) cap_trd <= t_rdata_out;
    if (frame_out === 1'b1) begin
      cap_cmd <= cmd_out;
      cap_addr <= ad_out;
    end
    if (data_phase_out === 1'b1 && dp_q !== 1'b1) begin
      cap_data <= ad_out;
      cap_be <= be_out;
    end
    if (t_claim_out === 1'b1) claim_cnt <= claim_cnt + 1;
    if (t_disc_out === 1'b1) disc_cnt <= disc_cnt + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One APB transfer: setup, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    rd_v = prdata_out;
    err_v = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp, msg);
  endtask
  task automatic bus_chk(input logic [3:0] c, input logic [31:0] a);
    chk({28'h0, cap_cmd}, {28'h0, c}, "bus command");
    chk(cap_addr, a, "bus address");
    chk({28'h0, cap_be}, 32'h0000_000F, "bus byte enables");
  endtask
  // One observed transfer to the local target: address phase, nph data phases
  task automatic tgt(input logic [3:0] c, input logic [31:0] a, input int nph, input logic [3:0] be,
                     input logic [31:0] d, input int ncl, input int ndc);
    int c0;
    int d0;
    c0 = claim_cnt;
    d0 = disc_cnt;
    t_addr_phase_in <= 1'b1;
    t_cmd_in <= c;
    t_ad_in <= a;
    @(posedge mclk_in);
    t_addr_phase_in <= 1'b0;
    t_data_phase_in <= 1'b1;
    t_be_in <= be;
    t_ad_in <= d;
    repeat (nph) @(posedge mclk_in);
    t_data_phase_in <= 1'b0;
    t_ad_in <= ~d;
    repeat (3) @(posedge mclk_in);
    chk(32'(claim_cnt - c0), 32'(ncl), "claim count");
    chk(32'(disc_cnt - d0), 32'(ndc), "disconnect count");
  endtask
  task automatic tcase(input logic [31:0] ctl, input logic sel, input logic [3:0] c, input logic [31:0] a, input int ncl);
    wr(`PCS_ADDR_TGTCTL, ctl);
    idsel_pin_in <= sel;
    repeat (4) @(posedge mclk_in); // Select pin settles ahead of the address phase
    tgt(c, a, 1, 4'hF, 32'h0000_0000, ncl, 0);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    wr(`PCS_ADDR_POINTER, `PCS_ALL_ONES);
    rd_chk(`PCS_ADDR_POINTER, `PCS_PTR_WMASK, "pointer fields");
    apb(1'b0, 32'h0000_0020, 32'h0000_0000);
    chk({31'h0, err_v}, 32'h0000_0001, "unmapped error");
    chk(rd_v, 32'h0000_0000, "unmapped data");
    wr(`PCS_ADDR_BUSNUM, 32'h0000_0005);
    rd_chk(`PCS_ADDR_BUSNUM, 32'h0000_0005, "bus number");
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0000, "status after reset");
  endtask
  task automatic t_bridge();
    wr(`PCS_ADDR_POINTER, 32'h8005_1A14);
    wr(`PCS_ADDR_DATA, 32'h1234_5678);
    bus_chk(`PCS_CMD_CFG_WR, 32'h0008_0214);
    chk(cap_data, 32'h1234_5678, "type 0 write data");
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0000, "claimed status");
    wr(`PCS_ADDR_POINTER, 32'h8005_A000);
    rd_chk(`PCS_ADDR_DATA, `PCS_ALL_ONES, "abort read");
    bus_chk(`PCS_CMD_CFG_RD, 32'h0000_0000);
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0001, "abort flag");
    wr(`PCS_ADDR_STATUS, 32'h0000_0001);
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0000, "abort flag cleared");
    wr(`PCS_ADDR_POINTER, 32'h8007_1A14);
    wr(`PCS_ADDR_DATA, 32'hCAFE_0001);
    bus_chk(`PCS_CMD_CFG_WR, 32'h0007_1A15);
    chk(cap_data, 32'hCAFE_0001, "type 1 write data");
    wr(`PCS_ADDR_STATUS, 32'h0000_0001);
  endtask
  task automatic t_special();
    wr(`PCS_ADDR_POINTER, 32'h8006_FF00);
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0000, "other bus not armed");
    wr(`PCS_ADDR_POINTER, 32'h8005_FF00);
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0002, "armed");
    wr(`PCS_ADDR_DATA, 32'hA5A5_1234);
    chk({28'h0, cap_cmd}, {28'h0, `PCS_CMD_SPECIAL}, "special command");
    chk(cap_data, 32'hA5A5_1234, "special data");
    wr(`PCS_ADDR_POINTER, 32'h8005_FF00);
    rd_chk(`PCS_ADDR_DATA, `PCS_ALL_ONES, "armed read");
    wr(`PCS_ADDR_STATUS, 32'h0000_0001);
    wr(`PCS_ADDR_POINTER, 32'h8005_FF04);
    rd_chk(`PCS_ADDR_STATUS, 32'h0000_0000, "disarmed");
  endtask
  task automatic t_claims();
    tcase(32'h0, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0510, 1);
    tcase(32'h0, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0511, 0);
    tcase(32'h0, 1'b1, 4'h6, 32'h0000_0510, 0);
    tcase(32'h0, 1'b0, `PCS_CMD_CFG_RD, 32'h0000_0510, 0);
    tcase(32'h2, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0510, 0);
    tcase(32'h2, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0010, 1);
    tcase(32'h45, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0410, 1);
    tcase(32'h45, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0310, 0);
    tcase(32'h45, 1'b1, `PCS_CMD_CFG_RD, 32'hFFFF_F810, 1);
    tcase(32'h41, 1'b1, `PCS_CMD_CFG_RD, 32'h0000_0010, 1);
  endtask
  task automatic t_store();
    wr(`PCS_ADDR_TGTCTL, 32'h0000_0000);
    tgt(`PCS_CMD_CFG_WR, 32'h0000_0010, 1, 4'hF, 32'h1111_2222, 1, 0);
    tgt(`PCS_CMD_CFG_RD, 32'h0000_0010, 1, 4'hF, 32'h0000_0000, 1, 0);
    chk(cap_trd, 32'h1111_2222, "full word");
    tgt(`PCS_CMD_CFG_WR, 32'h0000_0010, 1, 4'h5, 32'hAABB_CCDD, 1, 0);
    tgt(`PCS_CMD_CFG_RD, 32'h0000_0010, 1, 4'hF, 32'h0000_0000, 1, 0);
    chk(cap_trd, 32'h11BB_22DD, "byte lanes");
    tgt(`PCS_CMD_CFG_WR, 32'h0000_0020, 2, 4'hF, 32'h3333_4444, 1, 1);
    tgt(`PCS_CMD_CFG_RD, 32'h0000_0020, 1, 4'hF, 32'h0000_0000, 1, 0);
    chk(cap_trd, 32'h3333_4444, "burst first phase");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    mclk_in = 1'b0;
    reset_in = 1'b1;
    {psel_in, penable_in, pwrite_in, idsel_pin_in, t_addr_phase_in, t_data_phase_in} = '0;
    {paddr_in, pwdata_in, t_ad_in} = '0;
    {t_cmd_in, t_be_in} = '0;
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    t_regs();
    t_bridge();
    t_special();
    t_claims();
    t_store();
    conclude();
  end
endmodule
`default_nettype wire
